// ==== bench/iqual_checker_sva.sv ====
/* Port timing checker of the stream qualifier.
   Assumes binding to iqual_stream_qualifier; names follow its ports. */
`timescale 1ns/1ps
module iqual_checker (
    input wire logic clk_i, // Core clock
    input wire logic reset_i, // Synchronous reset
    input wire logic ce_i, // Clock enable
    input wire logic txn_valid_i, // Transaction offered
    input wire logic txn_ready_o, // Transaction taken
    input wire logic res_valid_o, // Result held
    input wire logic res_ready_i, // Result consumed
    input wire logic res_bypass_o, // Untranslated
    input wire logic res_abort_o, // Terminated
    input wire logic res_s1_en_o, // First stage applies
    input wire logic res_sub_valid_o, // Sub-context used
    input wire logic [7:0] res_s2_ctx_o, // Second stage context
    input wire logic [5:0] id_source_width_o, // Source tag width
    input wire logic [4:0] id_sub_width_o, // Sub-context width
    input wire logic [9:0] cmd_cons_o, // Command consumers
    input wire logic [1:0] cmd_fetch_o, // Command taken pulse
    input wire logic [9:0] evt_prod_o, // Event producers
    input wire logic [1:0] evt_wr_o, // Event pulse
    input wire logic [1:0] evt_code_o // Event cause
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (reset_i);
chk_result_latency: assert property (ce_i && txn_valid_i && txn_ready_o ##1 ce_i |=> res_valid_o)
    else $error("result missing two edges after take");
chk_result_hold: assert property (res_valid_o && !res_ready_i |=>
    res_valid_o && $stable(res_s2_ctx_o) && $stable(res_abort_o))
    else $error("result dropped before consumed");
chk_ready_free: assert property (!res_valid_o || res_ready_i |-> txn_ready_o)
    else $error("request refused with free result slot");
chk_sub_first_stage: assert property (res_valid_o && res_sub_valid_o |->
    res_s1_en_o && !res_bypass_o && !res_abort_o)
    else $error("sub-context used outside first stage");
chk_event_cause: assert property (evt_wr_o != 2'h0 |->
    res_valid_o && res_abort_o && evt_code_o != 2'h0)
    else $error("event without terminated result");
chk_event_advance: assert property (evt_wr_o[0] && $past(ce_i) |->
    evt_prod_o[4:0] == 5'($past(evt_prod_o[4:0]) + 5'h01))
    else $error("event producer did not advance");
chk_cmd_advance: assert property (cmd_fetch_o[1] && $past(ce_i) |->
    cmd_cons_o[9:5] == 5'($past(cmd_cons_o[9:5]) + 5'h01))
    else $error("secure command consumer did not advance");
chk_id_widths: assert property (!$past(reset_i) |->
    id_source_width_o == 6'h10 && id_sub_width_o == 5'h14)
    else $error("identification widths wrong");
endmodule // iqual_checker
bind iqual_stream_qualifier iqual_checker chk (.clk_i, .reset_i, .ce_i, .txn_valid_i,
    .txn_ready_o, .res_valid_o, .res_ready_i, .res_bypass_o, .res_abort_o, .res_s1_en_o,
    .res_sub_valid_o, .res_s2_ctx_o, .id_source_width_o, .id_sub_width_o, .cmd_cons_o,
    .cmd_fetch_o, .evt_prod_o, .evt_wr_o, .evt_code_o);

// ==== bench/iqual_client.sv ====
/* Client device model: offers one transaction and holds it until taken.
   Assumes issue is called from the bench's main process. */
`timescale 1ns/1ps
module iqual_client (
    input wire logic clk_i, // Core clock
    input wire logic ce_i, // Clock enable
    input wire logic ready_i, // Transaction taken
    output logic valid_o, // Transaction offered
    output logic [15:0] tag_o, // Source tag, no root complex bits above it
    output logic sec_o, // Secure namespace
    output logic sub_on_o, // Sub-context tag supplied
    output logic [19:0] sub_o // Sub-context tag
);
logic took = 1'b0;
initial {valid_o, tag_o, sec_o, sub_on_o, sub_o} = 39'h0;
// Take judged on what the edge itself saw, not on ready after it
always @(posedge clk_i) took <= ce_i & valid_o & ready_i;
task issue(input logic [15:0] t, input logic s, input logic p, input logic [19:0] u);
    begin
        @(negedge clk_i);
        {valid_o, tag_o, sec_o, sub_on_o, sub_o} = {1'b1, t, s, p, u};
        @(negedge clk_i);
        while (took !== 1'b1) begin
            @(negedge clk_i);
        end
        // Released lines show the inverse, never a stale copy
        {valid_o, tag_o, sec_o, sub_on_o, sub_o} = {1'b0, ~t, ~s, ~p, ~u};
    end
endtask
endmodule // iqual_client

// ==== bench/iqual_stream_qualifier_test.sv ====
/* Self-checking bench of the stream qualifier with one client model.
   Assumes design, checker and client files are compiled first. */
`timescale 1ns/1ps
module iqual_stream_qualifier_test;
reg clk_i = 1'b0;
reg reset_i = 1'b1;
reg ce_i = 1'b1;
reg res_ready_i = 1'b1;
reg cfg_wr_i = 1'b0;
reg cfg_secure_i = 1'b0;
reg [5:0] cfg_idx_i = 6'h00;
reg [20:0] cfg_data_i = 21'h000000;
reg [1:0] queue_en_i = 2'h3;
reg [1:0] xlate_en_i = 2'h3;
reg [4:0] ns_tbl_log2_i = 5'h04;
reg [4:0] s_tbl_log2_i = 5'h06;
reg [3:0] impl_ext_i = 4'h0;
reg [9:0] cmd_prod_i = 10'h000;
reg [9:0] evt_cons_i = 10'h000;
reg [1:0] evt_ovf_clr_i = 2'h0;
wire txn_valid_i, txn_ready_o, security_namespace_flag_i, sub_context_present_i;
wire [15:0] source_tag_i, evt_tag_o;
wire [19:0] sub_context_tag_i, res_sub_tag_o;
wire res_valid_o, res_bypass_o, res_abort_o, res_secure_o, res_s1_en_o, res_s2_en_o;
wire res_sub_valid_o;
wire [7:0] res_s1_ctx_o, res_s2_ctx_o;
wire [5:0] id_source_width_o;
wire [4:0] id_sub_width_o;
wire [9:0] cmd_cons_o, evt_prod_o;
wire [1:0] cmd_fetch_o, evt_wr_o, evt_code_o, evt_ovf_o;
integer failures = 0;
integer total_checks = 0;
integer cycles = 0;
iqual_stream_qualifier DUT (.clk_i, .reset_i, .ce_i, .txn_valid_i, .txn_ready_o,
    .source_tag_i, .sub_context_present_i, .sub_context_tag_i, .security_namespace_flag_i,
    .res_valid_o, .res_ready_i, .res_bypass_o, .res_abort_o, .res_secure_o, .res_s1_en_o,
    .res_s2_en_o, .res_s1_ctx_o, .res_sub_valid_o, .res_sub_tag_o, .res_s2_ctx_o,
    .cfg_wr_i, .cfg_secure_i, .cfg_idx_i, .cfg_data_i, .queue_en_i, .xlate_en_i,
    .ns_tbl_log2_i, .s_tbl_log2_i, .impl_ext_i, .id_source_width_o, .id_sub_width_o,
    .cmd_prod_i, .cmd_cons_o, .cmd_fetch_o, .evt_cons_i, .evt_prod_o, .evt_wr_o,
    .evt_code_o, .evt_tag_o, .evt_ovf_o, .evt_ovf_clr_i);
iqual_client cli (.clk_i, .ce_i, .ready_i(txn_ready_o), .valid_o(txn_valid_i),
    .tag_o(source_tag_i),
    .sec_o(security_namespace_flag_i), .sub_on_o(sub_context_present_i),
    .sub_o(sub_context_tag_i));
always #5 clk_i = ~clk_i;
task wrap_up;
    begin
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    end
endtask
always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
        failures = failures + 1;
        wrap_up;
    end
end
task chk(input logic [63:0] seen, input logic [63:0] exp);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    end
endtask
function logic [6:0] flags;
    flags = {res_valid_o, res_bypass_o, res_abort_o, res_secure_o, res_s1_en_o, res_s2_en_o,
        res_sub_valid_o};
endfunction
task put(input logic s, input logic [5:0] i, input logic [20:0] d);
    begin
        @(negedge clk_i);
        {cfg_wr_i, cfg_secure_i, cfg_idx_i, cfg_data_i} = {1'b1, s, i, d};
        @(negedge clk_i);
        cfg_wr_i = 1'b0;
    end
endtask
// Result registers land one edge after the take and stand one cycle
task go(input logic [15:0] t, input logic s, input logic p, input logic [19:0] u);
    begin
        cli.issue(t, s, p, u);
        @(negedge clk_i);
    end
endtask
task t_ident;
    begin
        @(negedge clk_i);
        chk(id_source_width_o, 6'h10);
        chk(id_sub_width_o, 5'h14);
    end
endtask
task t_lookup;
    begin
        put(1'b0, 6'h01, 21'h000001);
        put(1'b0, 6'h02, {8'hC3, 8'h5A, 5'h1F});
        put(1'b1, 6'h02, {8'h11, 8'h22, 5'h0F});
        go(16'h0001, 1'b0, 1'b1, 20'h12345);
        chk(flags(), 7'h60);
        go(16'h0002, 1'b0, 1'b1, 20'hABCDE);
        chk(flags(), 7'h47);
        chk({res_s1_ctx_o, res_s2_ctx_o, res_sub_tag_o}, {8'h5A, 8'hC3, 20'hABCDE});
        go(16'h0002, 1'b0, 1'b0, 20'h55555);
        chk(flags(), 7'h46);
        chk({res_s2_ctx_o, res_sub_tag_o}, {8'hC3, 20'h00000});
        go(16'h0002, 1'b1, 1'b0, 20'h00000);
        chk(flags(), 7'h4E);
        chk({res_s1_ctx_o, res_s2_ctx_o}, {8'h22, 8'h11});
        xlate_en_i = 2'h2;
        go(16'h0002, 1'b0, 1'b1, 20'h00001);
        chk(flags(), 7'h60);
        xlate_en_i = 2'h3;
    end
endtask
task bad(input logic [15:0] t, input logic s, input logic p, input logic [1:0] code);
    begin
        go(t, s, p, 20'h0F0F0);
        chk({res_valid_o, res_abort_o, evt_code_o, evt_tag_o}, {2'h3, code, t});
        chk(evt_wr_o, s ? 2'h2 : 2'h1);
    end
endtask
task t_aborts;
    begin
        put(1'b0, 6'h04, {8'h00, 8'h00, 5'h0B});
        bad(16'h0010, 1'b0, 1'b0, 2'h1);
        bad(16'h000F, 1'b0, 1'b0, 2'h2);
        bad(16'h0004, 1'b0, 1'b1, 2'h3);
        bad(16'h0040, 1'b1, 1'b0, 2'h1);
        bad(16'h0020, 1'b1, 1'b0, 2'h2);
        chk(evt_prod_o, {5'h02, 5'h03});
    end
endtask
task t_cmdq;
    begin
        queue_en_i = 2'h1;
        cmd_prod_i = {5'h02, 5'h01};
        ce_i = 1'b0;
        @(negedge clk_i);
        chk({cmd_fetch_o, cmd_cons_o}, 12'h000);
        ce_i = 1'b1;
        @(negedge clk_i);
        chk(cmd_fetch_o, 2'h1);
        @(negedge clk_i);
        chk({cmd_fetch_o, cmd_cons_o}, {2'h0, 5'h00, 5'h01});
        queue_en_i = 2'h3;
        repeat (2) @(negedge clk_i);
        chk({cmd_fetch_o, cmd_cons_o}, {2'h2, 5'h02, 5'h01});
        @(negedge clk_i);
        chk(cmd_fetch_o, 2'h0);
    end
endtask
// Held result must survive a second request arriving behind it
task t_stall;
    begin
        @(negedge clk_i);
        res_ready_i = 1'b0;
        go(16'h0001, 1'b0, 1'b0, 20'h00000);
        go(16'h0002, 1'b0, 1'b0, 20'h00000);
        chk({flags(), res_s2_ctx_o}, {7'h60, 8'h00});
        res_ready_i = 1'b1;
        @(negedge clk_i);
        chk({flags(), res_s2_ctx_o}, {7'h46, 8'hC3});
    end
endtask
task t_ovf;
    begin
        impl_ext_i = 4'h1;
        go(16'h0010, 1'b0, 1'b0, 20'h00000);
        chk({res_abort_o, evt_wr_o, evt_ovf_o}, {1'b1, 2'h0, 2'h0});
        impl_ext_i = 4'h0;
        queue_en_i = 2'h2;
        evt_ovf_clr_i = 2'h1;
        go(16'h0010, 1'b0, 1'b0, 20'h00000);
        chk({res_abort_o, evt_wr_o, evt_ovf_o}, {1'b1, 2'h0, 2'h1});
        @(negedge clk_i);
        chk(evt_ovf_o, 2'h0);
        evt_ovf_clr_i = 2'h0;
        queue_en_i = 2'h3;
    end
endtask
initial begin
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    t_ident;
    t_lookup;
    t_stall;
    t_aborts;
    t_ovf;
    t_cmdq;
    wrap_up;
end
endmodule // iqual_stream_qualifier_test

// ==== hdl/iqual_entry_table.v ====
/*
 * Flip-flop store of per-device configuration entries for both namespaces,
 * one write port and one combinational read port, both indexed.
 * Assumes the caller places the namespace flag in the top index bit.
 */
`timescale 1ns/1ps
`include "iqual_regs.vh"

module iqual_entry_table (
    input wire clk_i, // Core clock
    input wire reset_i, // Synchronous reset, active high
    input wire ce_i, // Clock enable
    input wire wr_en_i, // Entry write strobe
    input wire [`IQUAL_TBL_AW-1:0] wr_idx_i, // Entry written
    input wire [`IQUAL_ENT_W-1:0] wr_data_i, // Entry contents
    input wire [`IQUAL_TBL_AW-1:0] rd_idx_i, // Entry looked up
    output wire [`IQUAL_ENT_W-1:0] rd_data_o // Looked up entry
);
    wire [`IQUAL_ENT_W-1:0] ent_w [0:`IQUAL_TBL_DEPTH-1];

    genvar gi;
    generate
        for (gi = 0; gi < `IQUAL_TBL_DEPTH; gi = gi + 1) begin : g_ent
            reg [`IQUAL_ENT_W-1:0] ent_q;
            // Reset clears the valid bit so an unprogrammed entry terminates
            always @(posedge clk_i) begin
                if (reset_i) begin
                    ent_q <= `IQUAL_ENT_RESET;
                end else if (ce_i && wr_en_i && wr_idx_i == gi) begin
                    ent_q <= wr_data_i;
                end
            end
            assign ent_w[gi] = ent_q;
        end
    endgenerate

    assign rd_data_o = ent_w[rd_idx_i];

endmodule // iqual_entry_table

// ==== hdl/iqual_regs.vh ====
/*
 * Constants of the stream qualifier: tag widths, entry layout, queue sizes,
 * event codes and reset values.
 * Assumes inclusion by bare name from the qualifier's design files.
 */
`ifndef IQUAL_REGS_VH
`define IQUAL_REGS_VH

`define IQUAL_SRC_W 16
`define IQUAL_SUB_W 20
`define IQUAL_SRC_W_CODE 6'h10
`define IQUAL_SUB_W_CODE 5'h14
`define IQUAL_IDX_W 6
`define IQUAL_TBL_DEPTH 128
`define IQUAL_TBL_AW 7
`define IQUAL_SIZE_W 5

`define IQUAL_ENT_W 21
`define IQUAL_ENT_VALID 0
`define IQUAL_ENT_XLATE 1
`define IQUAL_ENT_S1EN 2
`define IQUAL_ENT_S2EN 3
`define IQUAL_ENT_SUBEN 4
`define IQUAL_ENT_S1_LSB 5
`define IQUAL_ENT_S1_MSB 12
`define IQUAL_ENT_S2_LSB 13
`define IQUAL_ENT_S2_MSB 20
`define IQUAL_ENT_RESET 21'h000000

`define IQUAL_Q_PTR_W 5
`define IQUAL_Q_DEPTH 5'h10

`define IQUAL_EV_NONE 2'h0
`define IQUAL_EV_BAD_TAG 2'h1
`define IQUAL_EV_BAD_ENTRY 2'h2
`define IQUAL_EV_BAD_SUB 2'h3

`endif

// ==== hdl/iqual_stream_qualifier.v ====
/*
 * Stream qualifier: takes client transactions tagged with a source tag,
 * optional sub-context tag and namespace flag, picks the per-device
 * configuration entry, decides bypass, translate or terminate, and keeps
 * the command and event queue indices of both namespaces.
 * Assumes requests come from logic on clk_i; queue memory is outside.
 */
// Function
// - Source tag input of fixed width
// - Sub-context tag of fixed width, twenty bits
// - Source tag selects one configuration entry
// - Per-transaction flag marks sub-context tag presence
// - Sub-context tag steers only first stage
// - Entry decides bypass, translation, stage selections
// - Second-stage-only builds have no sub-context input
// - First-stage builds may drop sub-context support
// - Namespace flag picks secure or non-secure table
// - Tag namespace private to this unit
// - Source tag at least sixteen bits
// - Zero extension fields keep architected behaviour
// - Tag widths readable through identification outputs
// - Global control enables queues and translation
// - Secure side has own queues, structures
// - Circular command and event queues
// - Tags beyond configured table size terminate
`timescale 1ns/1ps
`include "iqual_regs.vh"

module iqual_stream_qualifier (
    input wire clk_i, // Core clock, 100 MHz
    input wire reset_i, // Synchronous reset, active high
    input wire ce_i, // Clock enable, freezes state when low
    // Transaction request
    input wire txn_valid_i, // Transaction offered
    output wire txn_ready_o, // Transaction taken
    input wire [`IQUAL_SRC_W-1:0] source_tag_i, // Source tag
    input wire sub_context_present_i, // Sub-context tag supplied
    input wire [`IQUAL_SUB_W-1:0] sub_context_tag_i, // Sub-context tag
    input wire security_namespace_flag_i, // 1 = secure namespace
    // Qualified result
    output reg res_valid_o, // Result held
    input wire res_ready_i, // Result consumed
    output reg res_bypass_o, // Pass untranslated
    output reg res_abort_o, // Transaction terminated
    output reg res_secure_o, // Namespace of result
    output reg res_s1_en_o, // First stage applies
    output reg res_s2_en_o, // Second stage applies
    output reg [7:0] res_s1_ctx_o, // First stage context base
    output reg res_sub_valid_o, // Sub-context selects first stage
    output reg [`IQUAL_SUB_W-1:0] res_sub_tag_o, // Sub-context tag used
    output reg [7:0] res_s2_ctx_o, // Second stage context
    // Configuration entry writes
    input wire cfg_wr_i, // Write strobe
    input wire cfg_secure_i, // Target secure table
    input wire [`IQUAL_IDX_W-1:0] cfg_idx_i, // Entry index
    input wire [`IQUAL_ENT_W-1:0] cfg_data_i, // Entry contents
    // Global control and table extent, per namespace [1]=secure
    input wire [1:0] queue_en_i, // Queue processing enable
    input wire [1:0] xlate_en_i, // Translation enable
    input wire [`IQUAL_SIZE_W-1:0] ns_tbl_log2_i, // Non-secure table log2 size
    input wire [`IQUAL_SIZE_W-1:0] s_tbl_log2_i, // Secure table log2 size
    input wire [3:0] impl_ext_i, // Extension field, zero = architected
    // Identification
    output reg [5:0] id_source_width_o, // Source tag width
    output reg [4:0] id_sub_width_o, // Sub-context tag width
    // Command queues, [1]=secure
    input wire [`IQUAL_Q_PTR_W*2-1:0] cmd_prod_i, // Producer indices
    output wire [`IQUAL_Q_PTR_W*2-1:0] cmd_cons_o, // Consumer indices
    output wire [1:0] cmd_fetch_o, // Entry consumed pulse
    // Event queues, [1]=secure
    input wire [`IQUAL_Q_PTR_W*2-1:0] evt_cons_i, // Consumer indices
    output wire [`IQUAL_Q_PTR_W*2-1:0] evt_prod_o, // Producer indices
    output wire [1:0] evt_wr_o, // Event record pulse
    output reg [1:0] evt_code_o, // Event cause
    output reg [`IQUAL_SRC_W-1:0] evt_tag_o, // Offending source tag
    output wire [1:0] evt_ovf_o, // Event lost, sticky
    input wire [1:0] evt_ovf_clr_i // Overflow clear
);
    reg stage_valid_q;
    reg [`IQUAL_SRC_W-1:0] src_q;
    reg sub_pres_q;
    reg [`IQUAL_SUB_W-1:0] sub_q;
    reg sec_q;
    wire take_w;
    wire res_adv_w;
    wire [`IQUAL_ENT_W-1:0] ent_w;
    wire [`IQUAL_SIZE_W-1:0] log2_w;
    reg beyond_w;
    reg [1:0] code_w;
    reg [1:0] evt_req_w;
    integer bi;

    // Result slot is free when empty or consumed at this edge
    assign res_adv_w = ~res_valid_o | res_ready_i;
    // One transaction per cycle; refused only while stage and result both wait
    assign txn_ready_o = ~stage_valid_q | res_adv_w;
    assign take_w = ce_i & txn_valid_i & txn_ready_o;

    // Input stage; tags are taken per transaction, namespace is private
    always @(posedge clk_i) begin
        if (reset_i) begin
            stage_valid_q <= 1'b0;
            src_q <= {`IQUAL_SRC_W{1'b0}};
            sub_pres_q <= 1'b0;
            sub_q <= {`IQUAL_SUB_W{1'b0}};
            sec_q <= 1'b0;
        end else if (ce_i) begin
            // A staged transaction waits rather than overwrite a held result
            if (take_w || res_adv_w) begin
                stage_valid_q <= take_w;
            end
            if (take_w) begin
                src_q <= source_tag_i;
                sub_pres_q <= sub_context_present_i;
                sub_q <= sub_context_present_i ? sub_context_tag_i
                        : {`IQUAL_SUB_W{1'b0}};
                sec_q <= security_namespace_flag_i;
            end
        end
    end

    // Namespace flag forms top index bit, so each side has its own table
    iqual_entry_table u_table (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .wr_en_i(cfg_wr_i),
        .wr_idx_i({cfg_secure_i, cfg_idx_i}),
        .wr_data_i(cfg_data_i),
        .rd_idx_i({sec_q, src_q[`IQUAL_IDX_W-1:0]}),
        .rd_data_o(ent_w)
    );

    // Each namespace has its own programmed extent
    assign log2_w = sec_q ? s_tbl_log2_i : ns_tbl_log2_i;

    // Tags beyond the programmed extent or the entry store never alias
    always @* begin
        beyond_w = 1'b0;
        for (bi = 0; bi < `IQUAL_SRC_W; bi = bi + 1) begin
            if (src_q[bi] && (bi >= log2_w || bi >= `IQUAL_IDX_W)) begin
                beyond_w = 1'b1;
            end
        end
    end

    // First failing check decides the cause: extent, then entry, then sub tag
    always @* begin
        if (beyond_w) begin
            code_w = `IQUAL_EV_BAD_TAG;
        end else if (!ent_w[`IQUAL_ENT_VALID]) begin
            code_w = `IQUAL_EV_BAD_ENTRY;
        end else if (xlate_en_i[sec_q] && ent_w[`IQUAL_ENT_XLATE] && sub_pres_q
                && !(ent_w[`IQUAL_ENT_S1EN] && ent_w[`IQUAL_ENT_SUBEN])) begin
            // Sub-context without first stage or support has no target
            code_w = `IQUAL_EV_BAD_SUB;
        end else begin
            code_w = `IQUAL_EV_NONE;
        end
    end

    // Result register
    always @(posedge clk_i) begin
        if (reset_i) begin
            res_valid_o <= 1'b0;
            res_bypass_o <= 1'b0;
            res_abort_o <= 1'b0;
            res_secure_o <= 1'b0;
            res_s1_en_o <= 1'b0;
            res_s2_en_o <= 1'b0;
            res_s1_ctx_o <= 8'h00;
            res_sub_valid_o <= 1'b0;
            res_sub_tag_o <= {`IQUAL_SUB_W{1'b0}};
            res_s2_ctx_o <= 8'h00;
        end else if (ce_i) begin
            if (stage_valid_q && res_adv_w) begin
                res_valid_o <= 1'b1;
                res_secure_o <= sec_q;
                res_abort_o <= (code_w != `IQUAL_EV_NONE);
                if (code_w != `IQUAL_EV_NONE) begin
                    res_bypass_o <= 1'b0;
                    res_s1_en_o <= 1'b0;
                    res_s2_en_o <= 1'b0;
                    res_sub_valid_o <= 1'b0;
                end else if (!xlate_en_i[sec_q] || !ent_w[`IQUAL_ENT_XLATE]) begin
                    // Any sub-context tag is dropped along with translation
                    res_bypass_o <= 1'b1;
                    res_s1_en_o <= 1'b0;
                    res_s2_en_o <= 1'b0;
                    res_sub_valid_o <= 1'b0;
                end else begin
                    res_bypass_o <= 1'b0;
                    res_s1_en_o <= ent_w[`IQUAL_ENT_S1EN];
                    res_s2_en_o <= ent_w[`IQUAL_ENT_S2EN];
                    res_sub_valid_o <= sub_pres_q;
                end
                res_s1_ctx_o <= ent_w[`IQUAL_ENT_S1_MSB:`IQUAL_ENT_S1_LSB];
                res_sub_tag_o <= sub_q;
                // Second stage taken from the entry alone, never the sub tag
                res_s2_ctx_o <= ent_w[`IQUAL_ENT_S2_MSB:`IQUAL_ENT_S2_LSB];
            end else if (res_ready_i) begin
                res_valid_o <= 1'b0;
            end
        end
    end

    // Identification, constant after reset
    always @(posedge clk_i) begin
        if (reset_i) begin
            id_source_width_o <= 6'h00;
            id_sub_width_o <= 5'h00;
        end else if (ce_i) begin
            id_source_width_o <= `IQUAL_SRC_W_CODE;
            id_sub_width_o <= `IQUAL_SUB_W_CODE;
        end
    end

    // Event record; bit 0 of the extension mutes extent faults, zero keeps default
    always @* begin
        evt_req_w = 2'b00;
        // At most one record per transaction, raised as it enters the result slot
        if (stage_valid_q && res_adv_w
                && code_w != `IQUAL_EV_NONE
                && !(impl_ext_i[0] && code_w == `IQUAL_EV_BAD_TAG)) begin
            evt_req_w[sec_q] = 1'b1;
        end
    end

    // Cause and tag latch even when the record itself is lost
    always @(posedge clk_i) begin
        if (reset_i) begin
            evt_code_o <= `IQUAL_EV_NONE;
            evt_tag_o <= {`IQUAL_SRC_W{1'b0}};
        end else if (ce_i && evt_req_w != 2'b00) begin
            evt_code_o <= code_w;
            evt_tag_o <= src_q;
        end
    end

    // Per-namespace circular queues; page request queue absent, no such service
    genvar gn;
    generate
        for (gn = 0; gn < 2; gn = gn + 1) begin : g_ns
            reg [`IQUAL_Q_PTR_W-1:0] cmd_cons_q;
            reg cmd_fetch_q;
            reg [`IQUAL_Q_PTR_W-1:0] evt_prod_q;
            reg evt_wr_q;
            reg ovf_q;
            wire [`IQUAL_Q_PTR_W-1:0] cprod_w;
            wire [`IQUAL_Q_PTR_W-1:0] econs_w;
            wire [`IQUAL_Q_PTR_W-1:0] fill_w;
            wire cmd_go_w;
            wire evt_go_w;

            assign cprod_w = cmd_prod_i[gn*`IQUAL_Q_PTR_W +: `IQUAL_Q_PTR_W];
            assign econs_w = evt_cons_i[gn*`IQUAL_Q_PTR_W +: `IQUAL_Q_PTR_W];
            // Occupancy reaches sixteen only through the wrap bit
            assign fill_w = evt_prod_q - econs_w;
            // Index carries a wrap bit, so full and empty differ
            assign cmd_go_w = queue_en_i[gn] && cprod_w != cmd_cons_q;
            assign evt_go_w = evt_req_w[gn] && queue_en_i[gn]
                    && fill_w != `IQUAL_Q_DEPTH;

            always @(posedge clk_i) begin
                if (reset_i) begin
                    cmd_cons_q <= {`IQUAL_Q_PTR_W{1'b0}};
                    cmd_fetch_q <= 1'b0;
                    evt_prod_q <= {`IQUAL_Q_PTR_W{1'b0}};
                    evt_wr_q <= 1'b0;
                    ovf_q <= 1'b0;
                end else if (ce_i) begin
                    cmd_fetch_q <= cmd_go_w;
                    // One command per cycle while the producer is ahead
                    if (cmd_go_w) begin
                        cmd_cons_q <= cmd_cons_q + 5'h01;
                    end
                    evt_wr_q <= evt_go_w;
                    if (evt_go_w) begin
                        evt_prod_q <= evt_prod_q + 5'h01;
                    end
                    // Set beats a clear in the same cycle
                    if (evt_req_w[gn] && !evt_go_w) begin
                        ovf_q <= 1'b1;
                    end else if (evt_ovf_clr_i[gn]) begin
                        ovf_q <= 1'b0;
                    end
                end
            end

            assign cmd_cons_o[gn*`IQUAL_Q_PTR_W +: `IQUAL_Q_PTR_W] = cmd_cons_q;
            assign cmd_fetch_o[gn] = cmd_fetch_q;
            assign evt_prod_o[gn*`IQUAL_Q_PTR_W +: `IQUAL_Q_PTR_W] = evt_prod_q;
            assign evt_wr_o[gn] = evt_wr_q;
            assign evt_ovf_o[gn] = ovf_q;
        end
    endgenerate

endmodule // iqual_stream_qualifier
